// ---- sync_serial_pkg.sv ----
// Register map, field layout, encodings and bus carriers of the select-gated serial channel.
package sync_serial_pkg;

  // ***************************************
  // Register offsets (byte addresses)
  // ***************************************
  localparam int         ADDR_W           = 8;
  localparam logic [7:0] OFF_TX_BUF       = 8'h00;
  localparam logic [7:0] OFF_RX_BUF       = 8'h04;
  localparam logic [7:0] OFF_BIT_RATE     = 8'h08;
  localparam logic [7:0] OFF_MODE_SETUP   = 8'h0C;
  localparam logic [7:0] OFF_CTRL_ZERO    = 8'h10;
  localparam logic [7:0] OFF_CTRL_ONE     = 8'h14;
  localparam logic [7:0] OFF_SPECIAL_ONE  = 8'h18;
  localparam logic [7:0] OFF_SPECIAL_TWO  = 8'h1C;
  localparam logic [7:0] OFF_SPECIAL_THR  = 8'h20;
  localparam logic [7:0] OFF_SPECIAL_FOUR = 8'h24;
  localparam logic [7:0] OFF_PRESCALE     = 8'h28;

  // ***************************************
  // Field positions and write masks
  // ***************************************
  localparam int         BIT_OVERRUN      = 12;
  localparam int         BIT_CLK_SRC_SEL  = 3;
  localparam logic [2:0] SMD_SELECT_MODE  = 3'h1;
  localparam int         BIT_CS_SEL_LSB   = 0;
  localparam int         BIT_HS_FUNC_SEL  = 2;
  localparam int         BIT_SHIFT_EMPTY  = 3;
  localparam int         BIT_HS_OFF       = 4;
  localparam int         BIT_DRIVE_SEL    = 5;
  localparam int         BIT_EDGE_SEL     = 6;
  localparam int         BIT_ORDER_SEL    = 7;
  localparam int         BIT_TX_EN        = 0;
  localparam int         BIT_TX_BUF_EMPTY = 1;
  localparam int         BIT_RX_ALLOW     = 2;
  localparam int         BIT_RX_DONE      = 3;
  localparam int         BIT_TX_IRQ_SRC   = 4;
  localparam int         BIT_CONT_RX      = 5;
  localparam int         BIT_SEL_EN       = 0;
  localparam int         BIT_CLK_DELAY    = 1;
  localparam int         BIT_FAULT        = 2;
  localparam int         BIT_MS_SEL       = 3;
  localparam logic [7:0] CTRL_ZERO_WMASK  = 8'hF7;
  localparam logic [7:0] CTRL_ONE_WMASK   = 8'h35;
  localparam logic [7:0] SPECIAL_WMASK    = 8'h1B;
  localparam logic [7:0] RST_BYTE         = 8'h00;

  // ***************************************
  // Counts and bus answers
  // ***************************************
  localparam logic [4:0] DIV8_LAST        = 5'h07;
  localparam logic [4:0] DIV32_LAST       = 5'h1F;
  localparam logic [4:0] LAST_EDGE        = 5'h0F;
  localparam logic [3:0] LAST_SAMPLE      = 4'h7;
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;

  typedef enum logic [1:0] {ENG_IDLE = 2'b01, ENG_RUN = 2'b10} engine_state_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

endpackage : sync_serial_pkg

// ---- serial_prescaler.sv ----
// Count source prescaler: undivided or divided by twice the field value.
`timescale 1ns/1ps
module serial_prescaler #(
  parameter int PW = 4
) (
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic [PW-1:0] prescale_field,
  output logic               prescale_tick
);
  import sync_serial_pkg::*;

  typedef struct packed {
    logic [PW:0] cnt;
    logic        tick;
  } pre_state_t;

  pre_state_t s_r;
  pre_state_t s_nxt;
  logic [PW:0] last;

  if (PW < 1) begin : g_chk
    $error("Prescale field must be at least one bit wide.");
  end

  always_comb begin
    s_nxt = s_r;
    last  = {prescale_field, 1'b0} - (PW + 1)'(1);
    if (prescale_field == '0) begin
      s_nxt.cnt  = '0;
      s_nxt.tick = 1'b1;
    end else if (s_r.cnt >= last) begin
      s_nxt.cnt  = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt  = s_r.cnt + (PW + 1)'(1);
      s_nxt.tick = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prescale_tick = s_r.tick;

endmodule : serial_prescaler

// ---- bit_rate_gen.sv ----
// Bit-rate divider: one pulse per half period of the master transfer clock.
`timescale 1ns/1ps
module bit_rate_gen #(
  parameter int DW = 8
) (
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic [1:0]    count_source_select,
  input  wire logic          prescale_tick,
  input  wire logic [DW-1:0] divider,
  input  wire logic          run,
  output logic               bit_tick
);
  import sync_serial_pkg::*;

  typedef struct packed {
    logic [4:0]    free;
    logic [DW-1:0] cnt;
    logic          tick;
  } brg_state_t;

  brg_state_t s_r;
  brg_state_t s_nxt;
  logic       src;

  if (DW < 1) begin : g_chk
    $error("Divider must be at least one bit wide.");
  end

  always_comb begin
    s_nxt      = s_r;
    s_nxt.free = s_r.free + 5'h01;
    s_nxt.tick = 1'b0;
    case (count_source_select)
      2'h0:    src = 1'b1;
      2'h1:    src = (s_r.free[2:0] == DIV8_LAST[2:0]);
      2'h2:    src = (s_r.free == DIV32_LAST);
      default: src = prescale_tick;
    endcase
    if (!run) begin
      s_nxt.cnt = '0;
    end else if (src) begin
      if (s_r.cnt >= divider) begin
        s_nxt.cnt  = '0;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + DW'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bit_tick = s_r.tick;

endmodule : bit_rate_gen

// ---- select_gated_sync_serial.sv ----
// Select-gated clock-synchronous serial channel with an AXI4-Lite register slave.
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module select_gated_sync_serial (
  input  wire logic                       core_clk,
  input  wire logic                       nrst,
  input  wire sync_serial_pkg::axil_req_t axi_req,
  output sync_serial_pkg::axil_rsp_t      axi_rsp,
  input  wire logic                       transfer_clock_pin_i,
  output logic                            transfer_clock_pin_o,
  output logic                            transfer_clock_pin_oe,
  input  wire logic                       master_data_in_pin,
  output logic                            master_data_out_pin_o,
  output logic                            master_data_out_pin_oe,
  input  wire logic                       slave_data_in_pin,
  output logic                            slave_data_out_pin_o,
  output logic                            slave_data_out_pin_oe,
  input  wire logic                       select_input_pin_n,
  input  wire logic                       handshake_in_n,
  output logic                            tx_irq_req,
  output logic                            rx_irq_req
);
  import sync_serial_pkg::*;

  // ***************************************
  // State
  // ***************************************
  typedef struct packed {
    engine_state_t eng;
    logic [7:0]    txb;
    logic [7:0]    rxb;
    logic [7:0]    brg;
    logic [7:0]    mode;
    logic [7:0]    ctl0;
    logic [7:0]    ctl1;
    logic [7:0]    spc1;
    logic [7:0]    spc2;
    logic [7:0]    spc3;
    logic [7:0]    spc4;
    logic [3:0]    presc;
    logic          tx_full;
    logic          rx_full;
    logic          rx_done;
    logic          overrun;
    logic          fault;
    logic          rearm;
    logic [7:0]    sr;
    logic [4:0]    edges;
    logic [3:0]    samples;
    logic          sclk;
    logic          sclk_prev;
    logic          dout;
    logic          aw_got;
    logic          w_got;
    logic [7:0]    awaddr;
    logic [7:0]    wbyte;
    logic          wlane;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic          tx_irq;
    logic          rx_irq;
  } state_t;

  state_t      s_r;
  state_t      s_nxt;
  logic        prescale_tick;
  logic        bit_tick;
  logic        mode_on;
  logic        master;
  logic        slave;
  logic        sel_en;
  logic        lsb_first;
  logic        edge_sel;
  logic        delay_sel;
  logic        idle_lvl;
  logic        hs_ok;
  logic        can_go;
  logic        master_ok;
  logic        slave_sel;
  logic        in_bit;
  logic        rise;
  logic        fall;
  logic        smp_edge;
  logic        sft_edge;
  logic        finish;
  logic [7:0]  nsr;
  logic        rd_ok;
  logic [31:0] rd_data;
  logic        wr_ok;
  logic        ovr_set;

  // ***************************************
  // Count source and bit-rate generation
  // ***************************************
  serial_prescaler #(.PW(4)) u_pre (
    .core_clk       (core_clk),
    .nrst           (nrst),
    .prescale_field (s_r.presc),
    .prescale_tick  (prescale_tick)
  );

  bit_rate_gen #(.DW(8)) u_brg (
    .core_clk            (core_clk),
    .nrst                (nrst),
    .count_source_select (s_r.ctl0[BIT_CS_SEL_LSB +: 2]),
    .prescale_tick       (prescale_tick),
    .divider             (s_r.brg),
    .run                 ((s_r.eng == ENG_RUN) && master),
    .bit_tick            (bit_tick)
  );

  // ***************************************
  // Mode decode
  // ***************************************
  always_comb begin
    mode_on   = (s_r.mode[2:0] == SMD_SELECT_MODE) && (s_r.spc1 == RST_BYTE) &&
                (s_r.spc2 == RST_BYTE) && (s_r.spc4 == RST_BYTE);
    master    = mode_on && !s_r.spc3[BIT_MS_SEL] && !s_r.mode[BIT_CLK_SRC_SEL];
    slave     = mode_on && s_r.spc3[BIT_MS_SEL] && s_r.mode[BIT_CLK_SRC_SEL];
    sel_en    = s_r.spc3[BIT_SEL_EN];
    lsb_first = !s_r.ctl0[BIT_ORDER_SEL];
    edge_sel  = s_r.ctl0[BIT_EDGE_SEL];
    delay_sel = s_r.spc3[BIT_CLK_DELAY];
    idle_lvl  = !edge_sel ^ delay_sel;
    hs_ok     = s_r.ctl0[BIT_HS_OFF] || s_r.ctl0[BIT_HS_FUNC_SEL] || !handshake_in_n;
    can_go    = s_r.ctl1[BIT_TX_EN] && (s_r.tx_full || s_r.rearm);
    master_ok = master && !s_r.fault && !(sel_en && !select_input_pin_n);
    slave_sel = slave && !(sel_en && select_input_pin_n);
    in_bit    = master ? master_data_in_pin : slave_data_in_pin;
    rise      = master ? (bit_tick && !s_r.sclk) : (transfer_clock_pin_i && !s_r.sclk_prev);
    fall      = master ? (bit_tick && s_r.sclk) : (!transfer_clock_pin_i && s_r.sclk_prev);
    smp_edge  = edge_sel ? fall : rise;
    sft_edge  = edge_sel ? rise : fall;
  end

  // ***************************************
  // Register read decode
  // ***************************************
  always_comb begin
    rd_ok   = 1'b1;
    rd_data = '0;
    case (axi_req.araddr)
      OFF_TX_BUF:       rd_data[7:0] = RST_BYTE;
      OFF_RX_BUF: begin
        rd_data[7:0]       = s_r.rxb;
        rd_data[BIT_OVERRUN] = s_r.overrun;
      end
      OFF_BIT_RATE:     rd_data[7:0] = s_r.brg;
      OFF_MODE_SETUP:   rd_data[7:0] = s_r.mode;
      OFF_CTRL_ZERO: begin
        rd_data[7:0]           = s_r.ctl0;
        rd_data[BIT_SHIFT_EMPTY] = (s_r.eng == ENG_IDLE);
      end
      OFF_CTRL_ONE: begin
        rd_data[7:0]            = s_r.ctl1;
        rd_data[BIT_TX_BUF_EMPTY] = !s_r.tx_full;
        rd_data[BIT_RX_DONE]      = s_r.rx_done;
      end
      OFF_SPECIAL_ONE:  rd_data[7:0] = s_r.spc1;
      OFF_SPECIAL_TWO:  rd_data[7:0] = s_r.spc2;
      OFF_SPECIAL_THR: begin
        rd_data[7:0]     = s_r.spc3;
        rd_data[BIT_FAULT] = s_r.fault;
      end
      OFF_SPECIAL_FOUR: rd_data[7:0] = s_r.spc4;
      OFF_PRESCALE:     rd_data[3:0] = s_r.presc;
      default:          rd_ok = 1'b0;
    endcase
  end

  // ***************************************
  // Next state
  // ***************************************
  always_comb begin
    s_nxt           = s_r;
    s_nxt.tx_irq    = 1'b0;
    s_nxt.rx_irq    = 1'b0;
    s_nxt.sclk_prev = transfer_clock_pin_i;
    finish          = 1'b0;
    nsr             = s_r.sr;
    wr_ok           = 1'b1;
    ovr_set         = 1'b0;

    // Bus handshakes; a read of the receive buffer frees it before any new frame lands.
    if (axi_req.awvalid && !s_r.aw_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s_r.w_got && !s_r.bvalid) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wbyte = axi_req.wdata[7:0];
      s_nxt.wlane = axi_req.wstrb[0];
    end
    if (s_r.bvalid && axi_req.bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && axi_req.rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd_data;
      s_nxt.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      if (axi_req.araddr == OFF_RX_BUF) begin
        s_nxt.rx_full = 1'b0;
        s_nxt.rx_done = 1'b0;
        s_nxt.rearm   = s_r.ctl1[BIT_CONT_RX] && s_r.ctl1[BIT_TX_EN] &&
                        s_r.ctl1[BIT_RX_ALLOW];
      end
    end

    // Transfer engine.
    case (s_r.eng)
      ENG_IDLE: begin
        s_nxt.sclk = idle_lvl;
        if ((master_ok && hs_ok && can_go) || (slave_sel && can_go)) begin
          s_nxt.eng     = ENG_RUN;
          s_nxt.sr      = s_r.txb;
          s_nxt.tx_full = 1'b0;
          s_nxt.rearm   = 1'b0;
          s_nxt.edges   = '0;
          s_nxt.samples = '0;
          s_nxt.tx_irq  = s_r.tx_full && !s_r.ctl1[BIT_TX_IRQ_SRC];
          if (delay_sel) begin
            s_nxt.dout = lsb_first ? s_r.txb[0] : s_r.txb[7];
          end
        end
      end
      ENG_RUN: begin
        if ((master && !master_ok) || (slave && !slave_sel) || !mode_on) begin
          s_nxt.eng = ENG_IDLE;
        end else begin
          if (master && bit_tick) begin
            s_nxt.sclk  = !s_r.sclk;
            s_nxt.edges = s_r.edges + 5'h01;
          end
          if (sft_edge) begin
            s_nxt.dout = lsb_first ? s_r.sr[0] : s_r.sr[7];
          end
          if (smp_edge) begin
            nsr           = lsb_first ? {in_bit, s_r.sr[7:1]} : {s_r.sr[6:0], in_bit};
            s_nxt.sr      = nsr;
            s_nxt.samples = s_r.samples + 4'h1;
          end
          finish = master ? (bit_tick && (s_r.edges == LAST_EDGE))
                          : (smp_edge && (s_r.samples == LAST_SAMPLE));
        end
      end
      default: s_nxt.eng = ENG_IDLE;
    endcase

    if (finish) begin
      s_nxt.eng    = ENG_IDLE;
      s_nxt.tx_irq = s_r.ctl1[BIT_TX_IRQ_SRC];
      if (s_r.ctl1[BIT_RX_ALLOW]) begin
        if (s_nxt.rx_full) begin
          s_nxt.overrun = 1'b1;
          ovr_set       = 1'b1;
        end else begin
          s_nxt.rxb     = nsr;
          s_nxt.rx_full = 1'b1;
          s_nxt.rx_done = 1'b1;
          s_nxt.rx_irq  = 1'b1;
        end
      end
    end

    // Register writes land once both address and data are held.
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      case (s_r.awaddr)
        OFF_TX_BUF:       if (s_r.wlane) begin s_nxt.txb = s_r.wbyte; s_nxt.tx_full = 1'b1; end
        OFF_BIT_RATE:     if (s_r.wlane) s_nxt.brg = s_r.wbyte;
        OFF_MODE_SETUP:   if (s_r.wlane) s_nxt.mode = s_r.wbyte;
        OFF_CTRL_ZERO:    if (s_r.wlane) s_nxt.ctl0 = s_r.wbyte & CTRL_ZERO_WMASK;
        OFF_CTRL_ONE: begin
          if (s_r.wlane) begin
            s_nxt.ctl1 = s_r.wbyte & CTRL_ONE_WMASK;
            if (!s_r.wbyte[BIT_RX_ALLOW]) begin
              // A new overrun in the same cycle outranks the software clear.
              s_nxt.overrun = ovr_set;
            end
          end
        end
        OFF_SPECIAL_ONE:  if (s_r.wlane) s_nxt.spc1 = s_r.wbyte;
        OFF_SPECIAL_TWO:  if (s_r.wlane) s_nxt.spc2 = s_r.wbyte;
        OFF_SPECIAL_THR: begin
          if (s_r.wlane) begin
            s_nxt.spc3 = s_r.wbyte & SPECIAL_WMASK;
            if (!s_r.wbyte[BIT_FAULT]) begin
              s_nxt.fault = 1'b0;
            end
          end
        end
        OFF_SPECIAL_FOUR: if (s_r.wlane) s_nxt.spc4 = s_r.wbyte;
        OFF_PRESCALE:     if (s_r.wlane) s_nxt.presc = s_r.wbyte[3:0];
        OFF_RX_BUF:       wr_ok = 1'b1;
        default:          wr_ok = 1'b0;
      endcase
      s_nxt.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // A competing master pulls the select low; this outranks a software clear.
    if (master && sel_en && !select_input_pin_n) begin
      s_nxt.fault = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r      <= '0;
      s_r.eng  <= ENG_IDLE;
      s_r.sclk <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***************************************
  // Pins and bus outputs
  // ***************************************
  // Open drain only ever pulls low, so the pin level is left to the pull-up when the bit is 1.
  always_comb begin
    transfer_clock_pin_o   = s_r.sclk;
    transfer_clock_pin_oe  = master_ok;
    master_data_out_pin_o  = s_r.dout && !s_r.ctl0[BIT_DRIVE_SEL];
    master_data_out_pin_oe = master_ok && (!s_r.ctl0[BIT_DRIVE_SEL] || !s_r.dout);
    slave_data_out_pin_o   = s_r.dout && !s_r.ctl0[BIT_DRIVE_SEL];
    slave_data_out_pin_oe  = slave_sel && s_r.ctl1[BIT_TX_EN] &&
                             (!s_r.ctl0[BIT_DRIVE_SEL] || !s_r.dout);
    tx_irq_req             = s_r.tx_irq;
    rx_irq_req             = s_r.rx_irq;
    axi_rsp.awready        = !s_r.aw_got && !s_r.bvalid;
    axi_rsp.wready         = !s_r.w_got && !s_r.bvalid;
    axi_rsp.bvalid         = s_r.bvalid;
    axi_rsp.bresp          = s_r.bresp;
    axi_rsp.arready        = !s_r.rvalid;
    axi_rsp.rvalid         = s_r.rvalid;
    axi_rsp.rdata          = s_r.rdata;
    axi_rsp.rresp          = s_r.rresp;
  end

endmodule : select_gated_sync_serial

// ---- sync_serial_properties.sv ----
// Concurrent checks on the ports of the serial channel.
`timescale 1ns/1ps
module sync_serial_properties
  import sync_serial_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire axil_req_t  axi_req,
  input wire axil_rsp_t  axi_rsp,
  input wire logic       select_input_pin_n,
  input wire logic       transfer_clock_pin_oe,
  input wire logic       master_data_out_pin_oe,
  input wire logic       slave_data_out_pin_oe,
  input wire logic       tx_irq_req,
  input wire logic       rx_irq_req
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_bvalid_holds: assert property (axi_rsp.bvalid && !axi_req.bready |=>
    axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("bvalid dropped early");
  a_rvalid_holds: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("rvalid dropped early");
  a_write_refused: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken during response");
  a_read_refused: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken during response");
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
  a_tx_pulse: assert property (tx_irq_req |=> !tx_irq_req) else $error("tx request too long");
  a_rx_pulse: assert property (rx_irq_req |=> !rx_irq_req) else $error("rx request too long");
  // Two cycles of slack after the select pin changes keep these checks off the edge.
  a_slave_hiz: assert property (select_input_pin_n [*3] |-> !slave_data_out_pin_oe)
    else $error("slave drives while deselected");
  a_fault_hiz: assert property (!select_input_pin_n [*3] |->
    !transfer_clock_pin_oe && !master_data_out_pin_oe)
    else $error("master drives while select low");
  c_tx: cover property (tx_irq_req);
  c_rx: cover property (rx_irq_req);
  c_err: cover property (axi_rsp.bvalid && axi_rsp.bresp == RESP_SLVERR);
endmodule : sync_serial_properties

// ---- serial_partner.sv ----
// Behavioural far-end slave for the serial channel.
`timescale 1ns/1ps
module serial_partner (
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       msb,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte,
  output int              done_cnt
);
  // ****
  // Shifter
  // ****
  logic [2:0] cnt_r = 3'h0;
  logic [2:0] idx;
  assign idx = msb ? 3'h7 - cnt_r : cnt_r;
  initial begin
    miso = 1'b0;
    done_cnt = 0;
  end
  // Data moves on the falling edge so it is settled at the rising one.
  // A released line shows the inverse of its last bit, as nothing pulls it.
  always @(negedge sclk or posedge sel_n) begin
    if (sel_n) miso <= ~miso;
    else miso <= tx_byte[idx];
  end
  always @(posedge sclk or posedge sel_n) begin
    if (sel_n) begin
      cnt_r <= 3'h0;
    end else begin
      rx_byte[idx] <= mosi;
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == 3'h7) done_cnt <= done_cnt + 1;
    end
  end
endmodule : serial_partner

// ---- select_gated_sync_serial_tb.sv ----
// Register-level testbench of the select-gated serial channel.
`timescale 1ns/1ps
module select_gated_sync_serial_tb;
  import sync_serial_pkg::*;
  // ****
  // Signals
  // ****
  logic        core_clk, nrst, sel_n, pmsb, tco, tco_oe, mdo, mdo_oe, miso, txi, rxi, lt;
  logic        psel_n, hs_n;
  axil_req_t   rq;
  axil_rsp_t   rs;
  logic [7:0]  ptx, prx;
  logic [31:0] q;
  logic [1:0]  r;
  int          error_cnt, checked, txc, rxc, pdone, cyc, lastc, per;
  wire         sclk = tco_oe ? tco : 1'b1;
  wire         mosi = mdo_oe ? mdo : 1'b1;
  select_gated_sync_serial dut_u (.core_clk(core_clk), .nrst(nrst), .axi_req(rq), .axi_rsp(rs),
    .transfer_clock_pin_i(sclk), .transfer_clock_pin_o(tco), .transfer_clock_pin_oe(tco_oe),
    .master_data_in_pin(miso), .master_data_out_pin_o(mdo), .master_data_out_pin_oe(mdo_oe),
    .slave_data_in_pin(mosi), .slave_data_out_pin_o(), .slave_data_out_pin_oe(),
    .select_input_pin_n(sel_n), .handshake_in_n(hs_n), .tx_irq_req(txi), .rx_irq_req(rxi));
  serial_partner pt_u (.sclk(sclk), .mosi(mosi), .sel_n(psel_n), .msb(pmsb), .tx_byte(ptx),
    .miso(miso), .rx_byte(prx), .done_cnt(pdone));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    txc <= txc + txi;
    rxc <= rxc + rxi;
    lt <= tco;
    if (tco !== lt) begin
      per <= cyc - lastc;
      lastc <= cyc;
    end
  end
  // ****
  // Tasks
  // ****
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      $display("Error at %0t: got %h exp %h", $time, g, e);
      error_cnt++;
    end
  endtask : chk
  task summarize;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task acc(input logic we, input logic [7:0] a, input logic [31:0] d);
    logic [4:0] p, h;
    int n;
    @(posedge core_clk);
    p = we ? 5'h1C : 5'h03;
    n = 0;
    rq.awaddr <= a;
    rq.araddr <= a;
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    while (p != 5'h0) begin
      {rq.awvalid, rq.wvalid, rq.bready, rq.arvalid, rq.rready} <= p;
      @(negedge core_clk);
      h = p & {rs.awready, rs.wready, rs.bvalid, rs.arready, rs.rvalid};
      if (h[2]) r = rs.bresp;
      if (h[0]) {r, q} = {rs.rresp, rs.rdata};
      n++;
      if (n > 60) begin
        error_cnt++;
        summarize();
      end
      @(posedge core_clk);
      p = p & ~h;
    end
    {rq.awvalid, rq.wvalid, rq.bready, rq.arvalid, rq.rready} <= 5'h0;
  endtask : acc
  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask : rc
  task frm(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [7:0] pd);
    int c, n;
    c = pdone;
    ptx = pd;
    n = 0;
    psel_n <= 1'b0;
    acc(we, a, {24'h0, d});
    while (pdone == c && n < 600) begin
      @(posedge core_clk);
      n++;
    end
    q = 32'h0;
    while (q[BIT_SHIFT_EMPTY] !== 1'b1 && n < 600) begin
      acc(1'b0, OFF_CTRL_ZERO, 32'h0);
      n++;
    end
    psel_n <= 1'b1;
    if (n >= 600) begin
      error_cnt++;
      summarize();
    end
  endtask : frm
  // ****
  // Sequence
  // ****
  initial begin
    nrst = 1'b0;
    sel_n = 1'b1;
    psel_n = 1'b1;
    // The handshake input stays inactive, so only handshake_off or the handshake function select lets master frames start.
    hs_n = 1'b1;
    pmsb = 1'b0;
    ptx = 8'h00;
    rq = '0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    rc(OFF_BIT_RATE, 32'hFF, 32'h0);
    acc(1'b1, 8'h3C, 32'h1);
    chk(r, RESP_SLVERR);
    acc(1'b0, 8'h3C, 32'h0);
    chk(r, RESP_SLVERR);
    $display("Test bus done");
    acc(1'b1, OFF_BIT_RATE, 32'h1);
    acc(1'b1, OFF_MODE_SETUP, 32'h1);
    acc(1'b1, OFF_CTRL_ZERO, 32'h10);
    acc(1'b1, OFF_SPECIAL_THR, 32'h1);
    acc(1'b1, OFF_CTRL_ONE, 32'h4);
    acc(1'b1, OFF_TX_BUF, 32'hA5);
    // Nothing may move while transmit enable is clear, checked after a 60-cycle wait.
    repeat (60) @(posedge core_clk);
    chk(pdone, 0);
    rc(OFF_CTRL_ONE, 32'h2, 32'h0);
    frm(1'b1, OFF_CTRL_ONE, 8'h05, 8'h3C);
    chk(prx, 8'hA5);
    chk(per, 2);
    chk(txc, 1);
    rc(OFF_RX_BUF, 32'h10FF, 32'h3C);
    chk(rxc, 1);
    rc(OFF_CTRL_ONE, 32'h2, 32'h2);
    $display("Test frame done");
    pmsb = 1'b1;
    acc(1'b1, OFF_CTRL_ZERO, 32'hB0);
    acc(1'b1, OFF_CTRL_ONE, 32'h15);
    frm(1'b1, OFF_TX_BUF, 8'h96, 8'hC1);
    chk(prx, 8'h96);
    chk(txc, 2);
    rc(OFF_CTRL_ONE, 32'h8, 32'h8);
    frm(1'b1, OFF_TX_BUF, 8'h55, 8'h0F);
    chk(rxc, 2);
    rc(OFF_RX_BUF, 32'h1000, 32'h1000);
    acc(1'b1, OFF_CTRL_ONE, 32'h11);
    rc(OFF_RX_BUF, 32'h1000, 32'h0);
    $display("Test overrun done");
    acc(1'b1, OFF_PRESCALE, 32'h2);
    acc(1'b1, OFF_CTRL_ZERO, 32'hB3);
    frm(1'b1, OFF_TX_BUF, 8'h3A, 8'h00);
    chk(per, 8);
    chk(rxc, 2);
    sel_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    rc(OFF_SPECIAL_THR, 32'h4, 32'h4);
    sel_n <= 1'b1;
    acc(1'b1, OFF_SPECIAL_THR, 32'h1);
    rc(OFF_SPECIAL_THR, 32'h4, 32'h0);
    $display("Test fault done");
    // A read of the receive buffer alone must start a dummy frame of the old transmit data.
    acc(1'b1, OFF_CTRL_ONE, 32'h25);
    frm(1'b0, OFF_RX_BUF, 8'h00, 8'h5A);
    chk(prx, 8'h3A);
    chk(rxc, 3);
    rc(OFF_RX_BUF, 32'hFF, 32'h5A);
    $display("Test continuous done");
    summarize();
  end
endmodule : select_gated_sync_serial_tb
bind select_gated_sync_serial sync_serial_properties chk_u (.core_clk(core_clk), .nrst(nrst),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .select_input_pin_n(select_input_pin_n),
  .transfer_clock_pin_oe(transfer_clock_pin_oe), .master_data_out_pin_oe(master_data_out_pin_oe),
  .slave_data_out_pin_oe(slave_data_out_pin_oe), .tx_irq_req(tx_irq_req), .rx_irq_req(rx_irq_req));
